// file: core/pcm_port_defines.vh
/*
 holds the register map, field positions, reset values and framing codes
 of the pcm serial output port. assumes a plain verilog-2005 compile.
*/
// What this block does
// - unassigned slots float when the unassigned-slot tristate bit is set
// - slot width code 00 gives 32 bit clocks, 01 gives 16, 10 gives 24
// - data delay after frame edge: 000 one, 001 zero, 010 8, 011 12, 100 16
// - mode bit 0 selects stereo framing, 1 selects tdm; resets to tdm
// - frame polarity bit inverts how the frame clock is read
// - bit clock polarity 0 means capture on rising edge, 1 on falling
// - channel 0 goes into the slot chosen by bits 7 to 4
// - channel 0 drives its slot when drive bit set, else floats
// - first control register resets to 0x41
// - second control register resets to 0x00
// - channel 0 routing register resets to 0x01
`ifndef PCM_PORT_DEFINES_VH
`define PCM_PORT_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CTRL_ONE 8'h07
`define ADDR_CTRL_TWO 8'h08
`define ADDR_CH0_ROUTE 8'h09

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_CTRL_ONE 8'h41
`define RST_CTRL_TWO 8'h00
`define RST_CH0_ROUTE 8'h01
`define MASK_CTRL_ONE 8'h7f
`define MASK_CTRL_TWO 8'h03
`define MASK_CH0_ROUTE 8'hf1

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_HIZ_EN 6
`define BIT_WIDTH_HI 5
`define BIT_WIDTH_LO 4
`define BIT_DELAY_HI 3
`define BIT_DELAY_LO 1
`define BIT_MODE 0
`define BIT_FRAME_POL 1
`define BIT_BCLK_POL 0
`define BIT_SLOT_HI 7
`define BIT_SLOT_LO 4
`define BIT_DRV_EN 0

// ----------------------------------------
// framing codes
// ----------------------------------------
`define WIDTH_32 2'h0
`define WIDTH_16 2'h1
`define WIDTH_24 2'h2
`define DELAY_I2S 3'h0
`define DELAY_LJ 3'h1
`define DELAY_8 3'h2
`define DELAY_12 3'h3
`define DELAY_16 3'h4
`define LAST_SLOT 4'hf

`endif

// file: core/pcm_serial_port.v
/*
 serial pcm output port: control registers, framing engine and sample fifo.
 assumes bclk_pin and fsync_pin come from the host, far slower than clk_sys,
 and a register port and sample stream on clk_sys.
*/
`timescale 1ns/1ns
`include "pcm_port_defines.vh"

// ----------------------------------------
// sample fifo
// ----------------------------------------
module sample_fifo
#(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW = 4
)
(
	// clock
	input wire clk_sys,
	input wire sys_rst,
	input wire ce,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_r];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_ready & out_valid;

	always @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule // sample_fifo

// ----------------------------------------
// port top
// ----------------------------------------
module pcm_serial_port
#(
	parameter SAMPLE_W = 24,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
)
(
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	input wire ce,
	// register port
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// channel 0 sample stream
	input wire smp_valid,
	output wire smp_ready,
	input wire [SAMPLE_W-1:0] smp_data,
	// serial link, clocks from host
	input wire bclk_pin,
	input wire fsync_pin,
	output reg sdata_out,
	output reg sdata_oe
);
	reg [7:0] serial_port_control_one_r;
	reg [7:0] serial_port_control_two_r;
	reg [7:0] channel_zero_routing_r;
	reg [1:0] bclk_sync_r;
	reg [1:0] fsync_sync_r;
	reg bclk_d_r;
	reg frame_d_r;
	reg [4:0] delay_cnt_r;
	reg [4:0] bit_cnt_r;
	reg [4:0] slot_r;
	reg slot_live_r;
	reg [SAMPLE_W-1:0] shift_r;
	reg pop_r;
	wire unassigned_slot_hiz_en;
	wire [1:0] slot_width_sel;
	wire [2:0] data_delay_sel;
	wire framing_mode_sel;
	wire frame_clock_polarity;
	wire bit_clock_polarity;
	wire [3:0] ch0_slot_sel;
	wire ch0_drive_en;
	wire frame_sig;
	wire frame_edge;
	wire frame_start;
	wire launch_edge;
	wire [4:0] slot_last;
	wire fifo_valid;
	wire [SAMPLE_W-1:0] fifo_data;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function [4:0] slot_len_m1;
		input [1:0] code;
		begin
			case (code)
				`WIDTH_16: slot_len_m1 = 5'd15;
				`WIDTH_24: slot_len_m1 = 5'd23;
				default: slot_len_m1 = 5'd31;
			endcase
		end
	endfunction

	function [4:0] delay_bits;
		input [2:0] code;
		begin
			case (code)
				`DELAY_LJ: delay_bits = 5'd0;
				`DELAY_8: delay_bits = 5'd8;
				`DELAY_12: delay_bits = 5'd12;
				`DELAY_16: delay_bits = 5'd16;
				default: delay_bits = 5'd1;
			endcase
		end
	endfunction

	assign unassigned_slot_hiz_en = serial_port_control_one_r[`BIT_HIZ_EN];
	assign slot_width_sel =
		serial_port_control_one_r[`BIT_WIDTH_HI:`BIT_WIDTH_LO];
	assign data_delay_sel =
		serial_port_control_one_r[`BIT_DELAY_HI:`BIT_DELAY_LO];
	assign framing_mode_sel = serial_port_control_one_r[`BIT_MODE];
	assign frame_clock_polarity = serial_port_control_two_r[`BIT_FRAME_POL];
	assign bit_clock_polarity = serial_port_control_two_r[`BIT_BCLK_POL];
	assign ch0_slot_sel = channel_zero_routing_r[`BIT_SLOT_HI:`BIT_SLOT_LO];
	assign ch0_drive_en = channel_zero_routing_r[`BIT_DRV_EN];
	assign slot_last = slot_len_m1(slot_width_sel);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			serial_port_control_one_r <= `RST_CTRL_ONE;
			serial_port_control_two_r <= `RST_CTRL_TWO;
			channel_zero_routing_r <= `RST_CH0_ROUTE;
			reg_rdata <= 8'h00;
		end
		else if (ce)
		begin
			if (reg_wr)
			begin
				// reserved bits masked so they stay zero
				if (reg_addr == `ADDR_CTRL_ONE)
					serial_port_control_one_r <=
						reg_wdata & `MASK_CTRL_ONE;
				if (reg_addr == `ADDR_CTRL_TWO)
					serial_port_control_two_r <=
						reg_wdata & `MASK_CTRL_TWO;
				if (reg_addr == `ADDR_CH0_ROUTE)
					channel_zero_routing_r <=
						reg_wdata & `MASK_CH0_ROUTE;
			end
			if (reg_rd)
			begin
				case (reg_addr)
					`ADDR_CTRL_ONE: reg_rdata <= serial_port_control_one_r;
					`ADDR_CTRL_TWO: reg_rdata <= serial_port_control_two_r;
					`ADDR_CH0_ROUTE: reg_rdata <= channel_zero_routing_r;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// link sampling, host is clock master
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			bclk_sync_r <= 2'h0;
			fsync_sync_r <= 2'h0;
			bclk_d_r <= 1'b0;
			frame_d_r <= 1'b0;
		end
		else if (ce)
		begin
			bclk_sync_r <= {bclk_sync_r[0], bclk_pin};
			fsync_sync_r <= {fsync_sync_r[0], fsync_pin};
			bclk_d_r <= bclk_sync_r[1];
			frame_d_r <= frame_sig;
		end
	end

	// host captures on the selected edge, so data moves on the other one
	assign launch_edge = bit_clock_polarity ?
		(~bclk_d_r & bclk_sync_r[1]) : (bclk_d_r & ~bclk_sync_r[1]);
	assign frame_sig = fsync_sync_r[1] ^ frame_clock_polarity;
	assign frame_edge = frame_sig ^ frame_d_r;
	// tdm: a frame opens on the rise; stereo: both edges open a half
	assign frame_start = framing_mode_sel ?
		(frame_sig & ~frame_d_r) : frame_edge;

	// ----------------------------------------
	// framing engine
	// ----------------------------------------
	// fsync edge is seen at the same clk as its bclk edge and wins, so a
	// delay of zero is handled at frame start and still puts the first bit out on that edge
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			delay_cnt_r <= 5'd0;
			bit_cnt_r <= 5'd0;
			slot_r <= 5'd16;
			slot_live_r <= 1'b0;
			shift_r <= {SAMPLE_W{1'b0}};
			pop_r <= 1'b0;
			sdata_out <= 1'b0;
			sdata_oe <= 1'b0;
		end
		else if (ce)
		begin
			pop_r <= 1'b0;
			if (frame_start)
			begin
				delay_cnt_r <= delay_bits(data_delay_sel);
				bit_cnt_r <= 5'd0;
				slot_live_r <= 1'b0;
				// stereo: low half is slot 0, high half slot 1
				slot_r <= (framing_mode_sel | ~frame_sig) ? 5'd0 : 5'd1;
				if (framing_mode_sel | ~frame_sig)
				begin
					// empty fifo sends silence rather than stalling the link
					shift_r <= fifo_valid ? fifo_data : {SAMPLE_W{1'b0}};
					pop_r <= fifo_valid;
				end
				if (delay_bits(data_delay_sel) == 5'd0)
				begin
					slot_live_r <= 1'b1;
					sdata_out <= 1'b0;
					sdata_oe <= 1'b0;
				end
			end
			else if (launch_edge)
			begin
				if (delay_cnt_r > 5'd1)
					delay_cnt_r <= delay_cnt_r - 5'd1;
				else if (delay_cnt_r == 5'd1)
				begin
					delay_cnt_r <= 5'd0;
					slot_live_r <= 1'b1;
				end
				else if (bit_cnt_r == slot_last)
				begin
					bit_cnt_r <= 5'd0;
					// stereo halves hold one slot each
					if (framing_mode_sel && slot_r <= {1'b0, `LAST_SLOT})
						slot_r <= slot_r + 5'd1;
					else
						slot_live_r <= 1'b0;
				end
				else
					bit_cnt_r <= bit_cnt_r + 5'd1;
			end
			// output stage follows the counters one clk later
			if (!frame_start)
			begin
				if (!slot_live_r || slot_r > {1'b0, `LAST_SLOT})
				begin
					sdata_out <= 1'b0;
					sdata_oe <= ~unassigned_slot_hiz_en;
				end
				else if (slot_r[3:0] == ch0_slot_sel)
				begin
					// short slots truncate, long ones pad with zero
					sdata_out <= (bit_cnt_r < SAMPLE_W) ?
						shift_r[SAMPLE_W-1-bit_cnt_r] : 1'b0;
					sdata_oe <= ch0_drive_en;
				end
				else
				begin
					sdata_out <= 1'b0;
					sdata_oe <= ~unassigned_slot_hiz_en;
				end
			end
		end
	end

	// ----------------------------------------
	// sample buffer
	// ----------------------------------------
	sample_fifo
	#(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	)
	u_fifo
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ce(ce),
		.in_valid(smp_valid),
		.in_ready(smp_ready),
		.in_data(smp_data),
		.out_valid(fifo_valid),
		.out_ready(pop_r),
		.out_data(fifo_data)
	);
endmodule // pcm_serial_port

// file: sim/host_clock_model.sv
/*
 host model: makes bit and frame clocks, captures serial data.
 assumes clk_sys of 100 ns; frames of 128 bits, frame high for 64.
*/
`timescale 1ns/1ns
module host_clock_model
(
	// bench control
	input wire clk_sys,
	input wire run,
	input wire frame_inv,
	input wire cap_fall,
	// serial link
	input wire sdata_out,
	input wire sdata_oe,
	output reg bclk_pin,
	output reg fsync_pin,
	output reg [31:0] frames
);
	reg cap_d [0:127];
	reg cap_oe [0:127];
	integer i;
	initial
	begin
		bclk_pin = 1'b1;
		fsync_pin = 1'b0;
		frames = 0;
	end
	// edges 25 ns ahead of clk_sys so sync latency fits half a bit
	always @(posedge clk_sys)
	begin
		#75;
		bclk_pin = !cap_fall;
		fsync_pin = frame_inv;
		if (run)
		begin
			for (i = 0; i < 128; i = i + 1)
			begin
				bclk_pin = cap_fall;
				fsync_pin = (i < 64) ^ frame_inv;
				#400;
				bclk_pin = !cap_fall;
				cap_d[i] = sdata_out;
				cap_oe[i] = sdata_oe;
				#400;
			end
			frames = frames + 1;
		end
	end
endmodule // host_clock_model

// file: sim/pcm_port_properties.sv
/*
 concurrent checks on the ports of pcm_serial_port.
 assumes a bind from tb_top and ce held high.
*/
`timescale 1ns/1ns
module pcm_port_properties
(
	// watched ports
	input wire clk_sys,
	input wire sys_rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_rdata,
	input wire smp_valid,
	input wire smp_ready,
	input wire bclk_pin,
	input wire fsync_pin,
	input wire sdata_out,
	input wire sdata_oe
);
	// ----------------------------------------
	// cycles since link activity or a register write
	// ----------------------------------------
	reg [3:0] quiet_r;
	reg bclk_r;
	reg fsync_r;
	always @(posedge clk_sys)
	begin
		bclk_r <= bclk_pin;
		fsync_r <= fsync_pin;
		if (sys_rst || reg_wr || bclk_pin != bclk_r || fsync_pin != fsync_r)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	rd_unmapped_a:
	assert property (reg_rd && (reg_addr < 8'h07 || reg_addr > 8'h09)
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	ctl1_rsv_a:
	assert property (reg_rd && reg_addr == 8'h07 |=> !reg_rdata[7])
		else $error("control one bit 7 set");
	ctl2_rsv_a:
	assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata[7:2] == 6'h00)
		else $error("control two reserved set");
	route_rsv_a:
	assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata[3:1] == 3'h0)
		else $error("routing reserved set");
	link_quiet_a:
	assert property (quiet_r > 4'h8 |-> $stable(sdata_oe) && $stable(sdata_out))
		else $error("serial output moved without bit clock");
	ready_fall_a: assert property ($fell(smp_ready) |-> $past(smp_valid))
		else $error("ready fell without push");
	rst_clear_a:
	assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00
		&& !sdata_oe && smp_ready) else $error("reset state wrong");
	cover property (reg_rd && reg_addr == 8'h09);
	cover property ($fell(smp_ready));
	cover property ($rose(sdata_oe));
endmodule // pcm_port_properties

// file: sim/tb_top.sv
/*
 bench for pcm_serial_port against the host model.
 assumes core and sim sources compiled first.
*/
`timescale 1ns/1ns
module tb_top;
	reg clk_sys = 1'b0;
	reg sys_rst = 1'b1;
	reg ce = 1'b1;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg smp_valid = 1'b0;
	reg run = 1'b0;
	reg frame_inv = 1'b0;
	reg cap_fall = 1'b0;
	wire [23:0] smp_data = 24'hb4c3a5;
	wire [31:0] pat = {smp_data, 8'h00};
	wire [7:0] reg_rdata;
	wire smp_ready, bclk_pin, fsync_pin, sdata_out, sdata_oe;
	wire [31:0] frames;
	integer n_fail = 0;
	integer n_tests = 0;
	integer i;
	always #50 clk_sys = ~clk_sys;
	pcm_serial_port pcm_serial_port_inst (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
		.bclk_pin(bclk_pin), .fsync_pin(fsync_pin), .sdata_out(sdata_out),
		.sdata_oe(sdata_oe));
	host_clock_model host_clock_model_inst (.clk_sys(clk_sys), .run(run),
		.frame_inv(frame_inv), .cap_fall(cap_fall), .sdata_out(sdata_out),
		.sdata_oe(sdata_oe), .bclk_pin(bclk_pin), .fsync_pin(fsync_pin),
		.frames(frames));
	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task results;
	begin
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task chk_byte(input [7:0] got, input [7:0] exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	// serial bits from the host capture, oe and data
	task chk_bits(input integer f, input integer n, input [31:0] p, input e);
	integer k;
	begin
		for (k = 0; k < n; k = k + 1)
		begin
			n_tests = n_tests + 1;
			if (host_clock_model_inst.cap_oe[f+k] !== e || (e &&
				host_clock_model_inst.cap_d[f+k] !== p[31-k]))
			begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED %0t serial bit %0d", $time, f + k);
			end
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	end
	endtask
	task rd(input [7:0] a, input [7:0] e);
	begin
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		#1 chk_byte(reg_rdata, e);
		@(posedge clk_sys);
	end
	endtask
	task push(input integer n);
	begin
		smp_valid <= 1'b1;
		repeat (n) @(posedge clk_sys);
		smp_valid <= 1'b0;
		@(posedge clk_sys);
	end
	endtask
	task run_frames(input integer n);
	integer w;
	reg [31:0] f0;
	begin
		f0 = frames;
		w = 0;
		run <= 1'b1;
		while (frames < f0 + n && w < 1200 * n)
		begin
			@(posedge clk_sys);
			w = w + 1;
		end
		run <= 1'b0;
		if (frames < f0 + n)
		begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED %0t link timeout", $time);
			results;
		end
	end
	endtask
	// registers set while the link is idle, then two frames
	task setup(input [7:0] c1, input [7:0] c0, input [7:0] c2);
	begin
		wr(8'h07, c1);
		wr(8'h09, c0);
		wr(8'h08, c2);
		frame_inv <= c2[1];
		cap_fall <= c2[0];
		push(2);
		run_frames(2);
	end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task s_regs;
	begin
		// a write with ce low must be frozen out
		ce <= 1'b0;
		wr(8'h07, 8'h00);
		ce <= 1'b1;
		rd(8'h07, 8'h41);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h01);
		rd(8'h0a, 8'h00);
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h7f);
		wr(8'h08, 8'hff);
		rd(8'h08, 8'h03);
		wr(8'h09, 8'hff);
		rd(8'h09, 8'hf1);
	end
	endtask
	task s_formats;
	begin
		setup(8'h41, 8'h01, 8'h00);
		chk_bits(1, 32, pat, 1'b1);
		chk_bits(33, 24, 32'h0, 1'b0);
		setup(8'h13, 8'h21, 8'h00);
		chk_bits(32, 16, pat, 1'b1);
		chk_bits(0, 32, 32'h0, 1'b1);
		setup(8'h61, 8'h11, 8'h00);
		chk_bits(25, 24, pat, 1'b1);
		for (i = 0; i < 3; i = i + 1)
		begin
			setup(8'h45 + 8'(2 * i), 8'h01, 8'h00);
			chk_bits(8 + 4 * i, 8, pat, 1'b1);
		end
	end
	endtask
	task s_modes;
	begin
		setup(8'h41, 8'h01, 8'h03);
		chk_bits(1, 32, pat, 1'b1);
		setup(8'h41, 8'h00, 8'h00);
		chk_bits(0, 64, 32'h0, 1'b0);
		setup(8'h40, 8'h01, 8'h00);
		chk_bits(65, 32, pat, 1'b1);
		chk_bits(1, 24, 32'h0, 1'b0);
	end
	endtask
	// fifo filled past full with the link stopped, then drained
	task s_fifo;
	begin
		push(17);
		#1 chk_byte({7'h00, smp_ready}, 8'h00);
		@(posedge clk_sys);
		run_frames(16);
		#1 chk_byte({7'h00, smp_ready}, 8'h01);
		@(posedge clk_sys);
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		s_regs;
		s_formats;
		s_modes;
		s_fifo;
		results;
	end
endmodule // tb_top

bind pcm_serial_port pcm_port_properties pcm_port_properties_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
	.smp_ready(smp_ready), .bclk_pin(bclk_pin), .fsync_pin(fsync_pin),
	.sdata_out(sdata_out), .sdata_oe(sdata_oe));
